// [rtl/dmbc_pkg.sv]
// Shared constants and types for the DRAM mode, burst and DLL configuration block
package dmbc_pkg;

  // ----------------------------------------------------------------
  // Command and bank codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_MRS      = 4'h0;  // cs ras cas we all low
  localparam logic [3:0]  CMD_WR       = 4'h4;
  localparam logic [3:0]  CMD_RD       = 4'h5;
  localparam logic [2:0]  BA_PRIMARY   = 3'h0;
  localparam logic [2:0]  BA_SECONDARY = 3'h1;
  localparam logic [12:0] MODE_RST     = 13'h0000;

  // ----------------------------------------------------------------
  // Primary mode word fields
  // ----------------------------------------------------------------
  localparam int BL_LSB     = 0;
  localparam int CL_EXT_BIT = 2;
  localparam int BT_BIT     = 3;
  localparam int CL_LSB     = 4;
  localparam int DLLRST_BIT = 8;
  localparam int WR_LSB     = 9;
  localparam int PPD_BIT    = 12;
  localparam int BC_BIT     = 12;  // address bit that carries the chop select
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [4:0] CL_BASE = 5'h04;

  // ----------------------------------------------------------------
  // Secondary mode word fields
  // ----------------------------------------------------------------
  localparam int DLLDIS_BIT = 0;
  localparam int DIC_LO_BIT = 1;
  localparam int TERM_B0    = 2;
  localparam int AL_LSB     = 3;
  localparam int DIC_HI_BIT = 5;
  localparam int TERM_B1    = 6;
  localparam int WLVL_BIT   = 7;
  localparam int TERM_B2    = 9;
  localparam int QOFF_BIT   = 12;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;

  // ----------------------------------------------------------------
  // Burst and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] BEAT_LAST      = 3'h7;
  localparam logic [2:0] WR_PULL_IN_CLK = 3'h2;
  localparam logic [4:0] ROW_CLOSE_NCK  = 5'h09;
  localparam int SYS_PERIOD_NS  = 4;
  localparam int LINK_PERIOD_NS = 15;
  localparam int LOCK_WAIT_NCK  = 512;
  localparam int LOCK_WAIT_CYC  =
    (LOCK_WAIT_NCK * LINK_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  typedef enum logic [1:0] {CS_IDLE, CS_HOLD, CS_BURST} dmbc_cmd_state_e;
  typedef enum logic {BS_IDLE, BS_RUN} dmbc_beat_state_e;

endpackage

// [rtl/dmbc_beat_seq.sv]
// Beat order generator for one read or write burst
`timescale 1ns/1ns
`default_nettype none
module dmbc_beat_seq (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic [2:0] i_col,
  input  wire logic       i_interleave,
  input  wire logic       i_chop,
  input  wire logic       i_write,
  input  wire logic       i_outputs_off,
  output logic            o_busy,
  output logic            o_valid,
  output logic [2:0]      o_slot,
  output logic [2:0]      o_idx,
  output logic            o_drv_en,
  output logic            o_care
);

  // ----------------------------------------------------------------
  // Beat index for slot k of a burst
  // ----------------------------------------------------------------
  function automatic logic [2:0] beat_at(input logic [2:0] s, input logic [2:0] k,
                                         input logic ilv, input logic chop,
                                         input logic wr);
    logic [1:0] low;
    low = s[1:0] + k[1:0];
    if (wr) begin
      beat_at = chop ? {s[2], k[1:0]} : k;
    end else if (ilv) begin
      beat_at = s ^ k;
    end else begin
      beat_at = {s[2] ^ k[2], low};
    end
  endfunction

  dmbc_pkg::dmbc_beat_state_e bs_q, bs_d;
  logic [2:0] slot_q, slot_d, start_q, start_d, idx_q, idx_d, nxt;
  logic       ilv_q, ilv_d, chop_q, chop_d, wr_q, wr_d, off_q, off_d;
  logic       valid_q, valid_d, drv_q, drv_d, care_q, care_d;

  // ----------------------------------------------------------------
  // Slot sequencing
  // ----------------------------------------------------------------
  always_comb begin
    bs_d = bs_q;   slot_d = slot_q;   start_d = start_q;  idx_d = idx_q;
    ilv_d = ilv_q; chop_d = chop_q;   wr_d = wr_q;        off_d = off_q;
    valid_d = valid_q;  drv_d = drv_q;  care_d = care_q;
    nxt = slot_q + 3'h1;
    case (bs_q)
      dmbc_pkg::BS_IDLE: begin
        if (i_start) begin
          bs_d = dmbc_pkg::BS_RUN;
          slot_d = 3'h0;  start_d = i_col;  ilv_d = i_interleave;
          chop_d = i_chop;  wr_d = i_write;  off_d = i_outputs_off;
          idx_d = beat_at(i_col, 3'h0, i_interleave, i_chop, i_write);
          valid_d = 1'b1;
          drv_d = ~i_write & ~i_outputs_off;
          care_d = i_write;
        end
      end
      dmbc_pkg::BS_RUN: begin
        if (slot_q == dmbc_pkg::BEAT_LAST) begin
          bs_d = dmbc_pkg::BS_IDLE;
          valid_d = 1'b0;  drv_d = 1'b0;  care_d = 1'b0;
        end else begin
          slot_d = nxt;
          idx_d = beat_at(start_q, nxt, ilv_q, chop_q, wr_q);
          drv_d = ~wr_q & ~off_q & ~(chop_q & nxt[2]);
          care_d = wr_q & ~(chop_q & nxt[2]);
        end
      end
      default: bs_d = dmbc_pkg::BS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bs_q <= dmbc_pkg::BS_IDLE;  slot_q <= 3'h0;  start_q <= 3'h0;  idx_q <= 3'h0;
      ilv_q <= 1'b0;  chop_q <= 1'b0;  wr_q <= 1'b0;  off_q <= 1'b0;
      valid_q <= 1'b0;  drv_q <= 1'b0;  care_q <= 1'b0;
    end else begin
      bs_q <= bs_d;  slot_q <= slot_d;  start_q <= start_d;  idx_q <= idx_d;
      ilv_q <= ilv_d;  chop_q <= chop_d;  wr_q <= wr_d;  off_q <= off_d;
      valid_q <= valid_d;  drv_q <= drv_d;  care_q <= care_d;
    end
  end

  assign o_busy   = (bs_q == dmbc_pkg::BS_RUN);
  assign o_valid  = valid_q;
  assign o_slot   = slot_q;
  assign o_idx    = idx_q;
  assign o_drv_en = drv_q;
  assign o_care   = care_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_first_beat: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_start && !i_write && bs_q == dmbc_pkg::BS_IDLE |=> o_idx == $past(i_col))
    else $error("read burst does not start at column beat");
  chk_write_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && o_care |-> o_idx[1:0] == o_slot[1:0])
    else $error("write beat not in natural order");
  chk_chop_hiz: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && chop_q && o_slot[2] |-> !o_drv_en && !o_care)
    else $error("chopped burst drives or takes a tail slot");
  chk_burst_span: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_start && bs_q == dmbc_pkg::BS_IDLE |=> o_valid [*8] ##1 !o_valid)
    else $error("burst does not span eight slots");
  chk_ilv_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_valid && ilv_q && !wr_q |-> (o_idx ^ start_q) == o_slot)
    else $error("interleaved read order wrong");
  cov_ilv_read: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_start && i_interleave && !i_write && i_col == 3'h5);
  cov_chop_write: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_start && i_chop && i_write && i_col[2]);

endmodule
`default_nettype wire

// [rtl/dmbc_top.sv]
// Mode word capture, burst control and DLL lock tracking for the DRAM device
//
// Function
// - burst type bit selects sequential or interleaved
// - length field picks chop, full or on-the-fly
// - on-the-fly: address bit 12 picks length
// - full read starts at column beat order
// - full write ignores column, natural order
// - chopped read: four beats, tail high impedance
// - chopped write: nibble by column bit two
// - fixed chop pulls write timing two clocks
// - on-the-fly chop keeps full write timing
// - DLL reset bit clears itself after use
// - recovery field plus row close: autoclose delay
// - power-down exit bit freezes or keeps DLL
// - secondary word loads with only bank bit zero high
// - self refresh stops and restarts enabled DLL
// - driver impedance from secondary bits one, five
// - posted delay adds to both latencies
// - outputs off bit disconnects data, strobe drivers
// - primary word loads with all bank bits low
// - fetch latency from primary bits two, four-six
`timescale 1ns/1ns
`default_nettype none
module dmbc_top #(
  parameter int unsigned LOCK_WAIT_CYC = dmbc_pkg::LOCK_WAIT_CYC,
  parameter logic [4:0]  ROW_CLOSE_NCK = dmbc_pkg::ROW_CLOSE_NCK
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ck,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [2:0]  i_ba,
  input  wire logic [12:0] i_addr,
  input  wire logic [3:0]  i_store_latency,
  input  wire logic        i_self_refresh,
  input  wire logic        i_pwr_down,
  output logic             o_beat_valid,
  output logic [2:0]       o_beat_idx,
  output logic             o_dq_oe,
  output logic             o_dqs_oe,
  output logic             o_beat_care,
  output logic             o_wr_int_start,
  output logic [5:0]       o_fetch_lat,
  output logic [5:0]       o_store_lat,
  output logic [5:0]       o_autoclose_dly,
  output logic [1:0]       o_drv_imp,
  output logic [2:0]       o_term_sel,
  output logic             o_wr_level,
  output logic             o_outputs_off,
  output logic             o_dll_run,
  output logic             o_dll_locked
);

  // ----------------------------------------------------------------
  // Recovery code to clock cycles
  // ----------------------------------------------------------------
  function automatic logic [4:0] wr_cycles(input logic [2:0] c);
    if (c == 3'h0) begin
      wr_cycles = 5'h10;
    end else if (c < 3'h4) begin
      wr_cycles = {2'h0, c} + 5'h04;
    end else begin
      wr_cycles = {1'b0, c, 1'b0};
    end
  endfunction

  // ----------------------------------------------------------------
  // Link-domain reset release
  // ----------------------------------------------------------------
  logic rst_meta_q, link_rst_n_q;

  // Asynchronous assert, release aligned to the link clock
  always_ff @(posedge i_ck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q   <= 1'b0;
      link_rst_n_q <= 1'b0;
    end else begin
      rst_meta_q   <= 1'b1;
      link_rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [3:0] cmd;
  logic       ld_prim, ld_sec, is_rd, is_wr;

  // Mode words load from the address pins on a matching bank code
  assign cmd     = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  assign ld_prim = (cmd == dmbc_pkg::CMD_MRS) && (i_ba == dmbc_pkg::BA_PRIMARY);
  assign ld_sec  = (cmd == dmbc_pkg::CMD_MRS) && (i_ba == dmbc_pkg::BA_SECONDARY);
  assign is_rd   = (cmd == dmbc_pkg::CMD_RD);
  assign is_wr   = (cmd == dmbc_pkg::CMD_WR);

  // ----------------------------------------------------------------
  // Mode words
  // ----------------------------------------------------------------
  logic [12:0] prim_q, prim_d, sec_q, sec_d;
  logic        dll_tgl_q, dll_tgl_d;

  // Words change only on their own load; reset bit drops after one cycle
  always_comb begin
    prim_d = prim_q;
    sec_d = sec_q;
    dll_tgl_d = dll_tgl_q;
    prim_d[dmbc_pkg::DLLRST_BIT] = 1'b0;
    if (ld_prim) begin
      prim_d = i_addr;
      if (i_addr[dmbc_pkg::DLLRST_BIT]) begin
        dll_tgl_d = ~dll_tgl_q;  // DLL reset issued toward the lock timer
      end
    end
    if (ld_sec) begin
      sec_d = i_addr;
    end
  end

  always_ff @(posedge i_ck or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      prim_q    <= dmbc_pkg::MODE_RST;
      sec_q     <= dmbc_pkg::MODE_RST;
      dll_tgl_q <= 1'b0;
    end else begin
      prim_q    <= prim_d;
      sec_q     <= sec_d;
      dll_tgl_q <= dll_tgl_d;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [1:0] bl_mode;
  logic [4:0] cl, posted;
  logic [3:0] cl_code;

  assign bl_mode = prim_q[dmbc_pkg::BL_LSB +: 2];
  assign cl_code = {prim_q[dmbc_pkg::CL_EXT_BIT], prim_q[dmbc_pkg::CL_LSB +: 3]};
  assign cl      = dmbc_pkg::CL_BASE + {1'b0, cl_code};

  // Posted delay follows fetch latency
  always_comb begin
    case (sec_q[dmbc_pkg::AL_LSB +: 2])
      dmbc_pkg::AL_CL1: posted = cl - 5'h01;
      dmbc_pkg::AL_CL2: posted = cl - 5'h02;
      default:          posted = 5'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered settings toward the array and pads
  // ----------------------------------------------------------------
  logic [5:0] fetch_d, store_d, aclose_d;
  logic [5:0] fetch_q, store_q, aclose_q;
  logic [1:0] imp_d, imp_q;
  logic [2:0] term_d, term_q;
  logic       wlvl_d, wlvl_q, off_d, off_q, run_d, run_q;

  always_comb begin
    fetch_d  = {1'b0, posted} + {1'b0, cl};
    store_d  = {1'b0, posted} + {2'h0, i_store_latency};
    aclose_d = {1'b0, wr_cycles(prim_q[dmbc_pkg::WR_LSB +: 3])}
               + {1'b0, ROW_CLOSE_NCK};
    imp_d    = {sec_q[dmbc_pkg::DIC_HI_BIT], sec_q[dmbc_pkg::DIC_LO_BIT]};
    term_d   = {sec_q[dmbc_pkg::TERM_B2], sec_q[dmbc_pkg::TERM_B1],
                sec_q[dmbc_pkg::TERM_B0]};
    wlvl_d   = sec_q[dmbc_pkg::WLVL_BIT];
    off_d    = sec_q[dmbc_pkg::QOFF_BIT];
    // DLL halts in self refresh, and in power-down when slow exit is set
    run_d    = ~sec_q[dmbc_pkg::DLLDIS_BIT] & ~i_self_refresh
               & ~(i_pwr_down & ~prim_q[dmbc_pkg::PPD_BIT]);
  end

  always_ff @(posedge i_ck or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      fetch_q <= 6'h00;  store_q <= 6'h00;  aclose_q <= 6'h00;
      imp_q <= 2'h0;  term_q <= 3'h0;  wlvl_q <= 1'b0;  off_q <= 1'b0;  run_q <= 1'b0;
    end else begin
      fetch_q <= fetch_d;  store_q <= store_d;  aclose_q <= aclose_d;
      imp_q <= imp_d;  term_q <= term_d;  wlvl_q <= wlvl_d;  off_q <= off_d;  run_q <= run_d;
    end
  end

  assign o_fetch_lat     = fetch_q;
  assign o_store_lat     = store_q;
  assign o_autoclose_dly = aclose_q;
  assign o_drv_imp       = imp_q;
  assign o_term_sel      = term_q;
  assign o_wr_level      = wlvl_q;
  assign o_outputs_off   = off_q;
  assign o_dll_run       = run_q;

  // ----------------------------------------------------------------
  // Command hold and burst launch
  // ----------------------------------------------------------------
  dmbc_pkg::dmbc_cmd_state_e cs_q, cs_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] col_q, col_d;
  logic       chop_q, chop_d, wr_q, wr_d, fix_q, fix_d, launch;
  logic       seq_busy;
  logic [2:0] seq_slot;
  logic       seq_drv;

  // Read or write is taken at once and held for its total latency
  always_comb begin
    cs_d = cs_q;  cnt_d = cnt_q;  col_d = col_q;
    chop_d = chop_q;  wr_d = wr_q;  fix_d = fix_q;
    launch = 1'b0;
    case (cs_q)
      dmbc_pkg::CS_IDLE: begin
        if (is_rd || is_wr) begin
          cs_d   = dmbc_pkg::CS_HOLD;
          col_d  = i_addr[2:0];
          wr_d   = is_wr;
          fix_d  = (bl_mode == dmbc_pkg::BL_FIX4);
          chop_d = (bl_mode == dmbc_pkg::BL_FIX4)
                   | ((bl_mode == dmbc_pkg::BL_OTF) & ~i_addr[dmbc_pkg::BC_BIT]);
          cnt_d  = is_wr ? store_q : fetch_q;
        end
      end
      dmbc_pkg::CS_HOLD: begin
        if (cnt_q <= 6'h01) begin
          launch = 1'b1;
          cs_d   = dmbc_pkg::CS_BURST;
        end else begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      dmbc_pkg::CS_BURST: begin
        if (!seq_busy && !launch) begin
          cs_d = dmbc_pkg::CS_IDLE;
        end
      end
      default: cs_d = dmbc_pkg::CS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Internal write start: two clocks early only for fixed chop
  // ----------------------------------------------------------------
  logic       wrs_d, wrs_q;
  logic [2:0] wr_slot;

  always_comb begin
    wr_slot = fix_q ? (dmbc_pkg::BEAT_LAST - dmbc_pkg::WR_PULL_IN_CLK)
                    : dmbc_pkg::BEAT_LAST;
    wrs_d = seq_busy && wr_q && (seq_slot == wr_slot);
  end

  always_ff @(posedge i_ck or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      cs_q <= dmbc_pkg::CS_IDLE;  cnt_q <= 6'h00;  col_q <= 3'h0;
      chop_q <= 1'b0;  wr_q <= 1'b0;  fix_q <= 1'b0;  wrs_q <= 1'b0;
    end else begin
      cs_q <= cs_d;  cnt_q <= cnt_d;  col_q <= col_d;
      chop_q <= chop_d;  wr_q <= wr_d;  fix_q <= fix_d;  wrs_q <= wrs_d;
    end
  end

  assign o_wr_int_start = wrs_q;

  dmbc_beat_seq u_seq (
    .i_clk         (i_ck),
    .i_rst_n       (link_rst_n_q),
    .i_start       (launch),
    .i_col         (col_q),
    .i_interleave  (prim_q[dmbc_pkg::BT_BIT]),
    .i_chop        (chop_q),
    .i_write       (wr_q),
    .i_outputs_off (off_q),
    .o_busy        (seq_busy),
    .o_valid       (o_beat_valid),
    .o_slot        (seq_slot),
    .o_idx         (o_beat_idx),
    .o_drv_en      (seq_drv),
    .o_care        (o_beat_care)
  );

  assign o_dq_oe  = seq_drv;
  assign o_dqs_oe = seq_drv;

  // ----------------------------------------------------------------
  // DLL lock timer in the system domain
  // ----------------------------------------------------------------
  logic        tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic [11:0] lock_cnt_q, lock_cnt_d;
  logic        locked_q, locked_d;

  // Toggle crosses on two flops; the edge is taken from the second and third
  always_comb begin
    lock_cnt_d = lock_cnt_q;
    locked_d   = locked_q;
    if (tgl_s2_q ^ tgl_s3_q) begin
      lock_cnt_d = LOCK_WAIT_CYC[11:0];
      locked_d   = 1'b0;
    end else if (lock_cnt_q != 12'h000) begin
      lock_cnt_d = lock_cnt_q - 12'h001;
      locked_d   = (lock_cnt_q == 12'h001);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgl_s1_q <= 1'b0;  tgl_s2_q <= 1'b0;  tgl_s3_q <= 1'b0;
      lock_cnt_q <= 12'h000;  locked_q <= 1'b0;
    end else begin
      tgl_s1_q <= dll_tgl_q;  tgl_s2_q <= tgl_s1_q;  tgl_s3_q <= tgl_s2_q;
      lock_cnt_q <= lock_cnt_d;  locked_q <= locked_d;
    end
  end

  assign o_dll_locked = locked_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_dll_rst_clear: assert property (@(posedge i_ck) disable iff (!link_rst_n_q)
    prim_q[dmbc_pkg::DLLRST_BIT] && !ld_prim |=> !prim_q[dmbc_pkg::DLLRST_BIT])
    else $error("DLL reset bit did not clear");
  chk_prim_load: assert property (@(posedge i_ck) disable iff (!link_rst_n_q)
    ld_prim |=> prim_q == $past(i_addr))
    else $error("primary word not loaded");
  chk_sec_load: assert property (@(posedge i_ck) disable iff (!link_rst_n_q)
    ld_sec |=> sec_q == $past(i_addr) ##1 o_drv_imp == {$past(sec_q[5]), $past(sec_q[1])})
    else $error("secondary word not loaded");
  chk_words_hold: assert property (@(posedge i_ck) disable iff (!link_rst_n_q)
    !ld_sec && !ld_prim |=> $stable(sec_q) && $stable(prim_q[12:9]))
    else $error("mode word changed without a load");
  chk_outputs_off: assert property (@(posedge i_ck) disable iff (!link_rst_n_q)
    o_outputs_off && launch |=> !o_dq_oe [*8])
    else $error("drivers on while outputs are off");
  chk_wr_pull_in: assert property (@(posedge i_ck) disable iff (!link_rst_n_q)
    launch && wr_q && fix_q |=> ##6 o_wr_int_start)
    else $error("fixed chop write start not pulled in");
  chk_otf_chop: assert property (@(posedge i_ck) disable iff (!link_rst_n_q)
    cs_q == dmbc_pkg::CS_IDLE && is_rd && bl_mode == dmbc_pkg::BL_OTF |=>
    chop_q == !$past(i_addr[12]))
    else $error("on-the-fly chop not taken from address bit 12");
  chk_dll_freeze: assert property (@(posedge i_ck) disable iff (!link_rst_n_q)
    (i_self_refresh || (i_pwr_down && !prim_q[12])) |=> !o_dll_run)
    else $error("DLL runs while it must be stopped");
  cov_dll_reset: cover property (@(posedge i_ck) disable iff (!link_rst_n_q)
    ld_prim && i_addr[dmbc_pkg::DLLRST_BIT]);
  cov_otf_write: cover property (@(posedge i_ck) disable iff (!link_rst_n_q)
    launch && wr_q && chop_q && !fix_q);

endmodule
`default_nettype wire

// [test/dmbc_ctrl_model.sv]
// Memory controller model driving the command and address pins
`timescale 1ns/1ns
`default_nettype none
module dmbc_ctrl_model (
  input  wire logic   i_ck,
  output logic [3:0]  o_cmd,
  output logic [2:0]  o_ba,
  output logic [12:0] o_addr
);
  // Idle bus is deselect
  initial begin
    o_cmd = 4'hF;
    o_ba = 3'h0;
    o_addr = 13'h0000;
  end
  // One command for one link clock, then deselect with the address inverted
  task send(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    @(posedge i_ck);
    o_cmd <= c;
    o_ba <= b;
    o_addr <= a;
    @(posedge i_ck);
    o_cmd <= 4'hF;
    o_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the mode, burst and DLL block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic        sys_clk = 1'b0, ck = 1'b0, rst_n = 1'b0, sr = 1'b0, pd = 1'b0, qoff = 1'b0;
  logic [3:0]  cmd, store_latency = 4'h5;
  logic [2:0]  ba, idx, term;
  logic [12:0] addr;
  logic [5:0]  fl, stl, acd;
  logic [1:0]  imp;
  logic        bv, dq, dqs, care, wst, off, run, lck, wlv;
  int          n_errors = 0, n_tests = 0, cyc = 0;
  // System clock and a 15 ns link clock of its own phase
  always #2 sys_clk = ~sys_clk;
  always begin #7 ck = 1'b1; #8 ck = 1'b0; end
  dmbc_ctrl_model i_ctrl (.i_ck(ck), .o_cmd(cmd), .o_ba(ba), .o_addr(addr));
  dmbc_top #(.LOCK_WAIT_CYC(20)) i_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_ck(ck),
    .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba),
    .i_addr(addr), .i_store_latency(store_latency), .i_self_refresh(sr), .i_pwr_down(pd),
    .o_beat_valid(bv), .o_beat_idx(idx), .o_dq_oe(dq), .o_dqs_oe(dqs), .o_beat_care(care),
    .o_wr_int_start(wst), .o_fetch_lat(fl), .o_store_lat(stl), .o_autoclose_dly(acd),
    .o_drv_imp(imp), .o_term_sel(term), .o_wr_level(wlv), .o_outputs_off(off),
    .o_dll_run(run), .o_dll_locked(lck));
  // Verdict and end of run
  task test_done;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin n_errors++; test_done; end
  end
  // Expected beat number for slot k from start s
  function automatic logic [2:0] eidx(logic [2:0] s, k, logic il, wr, ch);
    if (wr) return ch ? {s[2], k[1:0]} : k;
    if (il) return s ^ k;
    return {s[2] ^ k[2], s[1:0] + k[1:0]};
  endfunction
  // Mode word load, then time for the decode
  task mrs(input logic [2:0] b, input logic [12:0] w);
    i_ctrl.send(dmbc_pkg::CMD_MRS, b, w);
    repeat (2) @(posedge ck);
  endtask
  // One burst with its slots judged one by one
  task burst(input logic wr, il, ch, fix, input logic [12:0] a);
    int k, w;
    w = 0;
    i_ctrl.send(wr ? dmbc_pkg::CMD_WR : dmbc_pkg::CMD_RD, 3'h0, a);
    for (k = 0; k < 40 && bv !== 1'b1; k++) @(negedge ck);
    `CHK("lat", wr ? 21 : 26, k)
    for (k = 0; k < 10; k++) begin
      if (k < 8 && !(ch && k > 3)) `CHK("idx", eidx(a[2:0], k[2:0], il, wr, ch), idx)
      if (k < 8 && !wr) `CHK("oe", {2{!(ch && k > 3) && !qoff}}, {dq, dqs})
      if (k < 8 && wr) `CHK("care", !(ch && k > 3), care)
      if (wst === 1'b1) w = k;
      @(negedge ck);
    end
    if (wr) `CHK("wstart", fix ? 6 : 8, w)
  endtask
  // Decoded latencies and driver settings, foreign bank ignored
  task t_decode;
    mrs(dmbc_pkg::BA_PRIMARY, 13'h0614);
    mrs(dmbc_pkg::BA_SECONDARY, 13'h02AC);
    mrs(3'h2, 13'h1FFF);
    `CHK("decode", {6'h19, 6'h11, 6'h10, 2'h2, 3'h5, 1'b1}, {fl, stl, acd, imp, term, wlv})
    store_latency <= 4'h8;
    repeat (2) @(posedge ck);
    `CHK("store", 6'h14, stl)
  endtask
  // Read with outputs disconnected
  task t_qoff;
    qoff = 1'b1;
    mrs(dmbc_pkg::BA_SECONDARY, 13'h12AC);
    `CHK("off", 1'b1, off)
    burst(1'b0, 1'b0, 1'b0, 1'b0, 13'h0005);
    qoff = 1'b0;
    mrs(dmbc_pkg::BA_SECONDARY, 13'h02AC);
  endtask
  // Every length mode and type, reads and writes
  task t_bursts;
    int bt, bl, wr;
    for (bt = 0; bt < 2; bt++) for (bl = 0; bl < 3; bl++) for (wr = 0; wr < 2; wr++) begin
      mrs(dmbc_pkg::BA_PRIMARY, 13'h0614 | 13'(bt << 3) | 13'(bl));
      burst(wr[0], bt[0], bl == 2 || (bl == 1 && bt == 0), bl == 2, 13'(bt << 12) | 13'h0005);
    end
  endtask
  // DLL state under self refresh and power-down
  task runchk(input logic s, p, e);
    @(posedge ck) begin sr <= s; pd <= p; end
    repeat (3) @(posedge ck);
    `CHK("run", e, run)
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ck);
    t_decode;
    t_qoff;
    t_bursts;
    repeat (2) begin
      mrs(dmbc_pkg::BA_PRIMARY, 13'h0714);
      `CHK("lock", 1'b0, lck)
      repeat (40) @(posedge sys_clk);
      `CHK("lock", 1'b1, lck)
    end
    runchk(1'b1, 1'b0, 1'b0);
    runchk(1'b0, 1'b0, 1'b1);
    runchk(1'b0, 1'b1, 1'b0);
    runchk(1'b0, 1'b0, 1'b1);
    mrs(dmbc_pkg::BA_PRIMARY, 13'h1614);
    runchk(1'b0, 1'b1, 1'b1);
    // DLL off with termination held off
    mrs(dmbc_pkg::BA_SECONDARY, 13'h0001);
    `CHK("dlloff", 3'h0, term)
    runchk(1'b0, 1'b0, 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
